// >>> verilog/seq_pkg.sv
package seq_pkg;

  // ----------------------------------------
  // Timing at 125 MHz
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned HARD_RST_DELAY_MS = 200;
  localparam int unsigned PWR_OFF_PRESS_S = 8;
  localparam int unsigned PWR_ON_HOLD_MS = 600;
  localparam int unsigned HARD_RST_DELAY_CYC = HARD_RST_DELAY_MS * CLK_KHZ;
  localparam int unsigned PWR_OFF_PRESS_CYC = PWR_OFF_PRESS_S * 1000 * CLK_KHZ;
  localparam int unsigned PWR_ON_HOLD_CYC = PWR_ON_HOLD_MS * CLK_KHZ;
  localparam int unsigned RAMP_STEP_CYC = 1250;
  localparam int unsigned TIMER_W = 32;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_ASSERTED = 1'h0;
  localparam logic CARD_BANK_DEFAULT = 1'h1;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_WAIT = 3'b001,
    ST_RAMP = 3'b010,
    ST_ON = 3'b011,
    ST_SOFT_OFF = 3'b100
  } seq_state_e;

  // Synchronised pin levels
  typedef struct packed {
    logic power_cycle_n;
    logic button_n;
    logic cold_n;
    logic mcu_warm_n;
    logic main_warm_n;
    logic supply;
    logic vsel;
    logic wdog;
  } pins_s;

  // Reset status outputs
  typedef struct packed {
    logic cold_n;
    logic mcu_warm_n;
    logic main_warm_n;
  } status_s;

endpackage

// >>> verilog/module_reset_power_sequencer.sv
`timescale 1ns/1ps
module module_reset_power_sequencer #(
  parameter int unsigned HARD_RST_DELAY = seq_pkg::HARD_RST_DELAY_CYC,
  parameter int unsigned PWR_OFF_PRESS = seq_pkg::PWR_OFF_PRESS_CYC,
  parameter int unsigned PWR_ON_HOLD = seq_pkg::PWR_ON_HOLD_CYC,
  parameter int unsigned RAMP_STEP = seq_pkg::RAMP_STEP_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic module_power_cycle_reset_n,
  input wire logic power_button_n,
  input wire logic cold_reset_in_n,
  input wire logic mcu_domain_warm_reset_n,
  input wire logic main_domain_warm_reset_req_n,
  input wire logic main_supply_present,
  input wire logic card_bank_voltage_select,
  input wire logic watchdog_expired,
  output logic supply_enable,
  output logic cold_reset_status_n,
  output logic mcu_domain_warm_reset_status_n,
  output logic main_domain_warm_reset_status_n,
  output logic power_sequence_done,
  output logic card_bank_supply
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  seq_pkg::pins_s raw;
  seq_pkg::pins_s meta_r;
  seq_pkg::pins_s sync_r;

  assign raw = '{module_power_cycle_reset_n, power_button_n, cold_reset_in_n,
                 mcu_domain_warm_reset_n, main_domain_warm_reset_req_n,
                 main_supply_present, card_bank_voltage_select, watchdog_expired};

  // Reset values assert hard reset and show no supply; the other pins start at their inactive levels
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
      sync_r <= '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
    end
    else if (clock_en)
    begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_pkg::seq_state_e state_r, state_nxt;
  logic [seq_pkg::TIMER_W-1:0] timer_r, timer_nxt;
  logic [seq_pkg::TIMER_W-1:0] btn_cnt_r, btn_cnt_nxt;
  logic btn_lvl_r, btn_lvl_nxt;
  logic first_done_r, first_done_nxt;
  logic off_req, on_req;
  logic power_ok;

  // Both power conditions must hold at once
  assign power_ok = sync_r.power_cycle_n & sync_r.supply;

  // Button run length: restarts on every level change, so a glitch resets it
  always_comb
  begin
    btn_lvl_nxt = sync_r.button_n;
    btn_cnt_nxt = btn_cnt_r;
    if (!first_done_r)
      btn_cnt_nxt = '0;
    else if (sync_r.button_n != btn_lvl_r)
      btn_cnt_nxt = '0;
    else if (btn_cnt_r != '1)
      btn_cnt_nxt = btn_cnt_r + 1'h1;
  end

  // Long low press and held high level decoded from the run length
  assign off_req = first_done_r && !btn_lvl_r &&
                   btn_cnt_r == seq_pkg::TIMER_W'(PWR_OFF_PRESS - 1);
  assign on_req = first_done_r && btn_lvl_r &&
                  btn_cnt_r == seq_pkg::TIMER_W'(PWR_ON_HOLD - 1);

  // Next state; hard reset or supply loss always wins and powers down
  always_comb
  begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    first_done_nxt = first_done_r;
    if (!power_ok)
    begin
      state_nxt = seq_pkg::ST_OFF;
      timer_nxt = '0;
    end
    else
    begin
      case (state_r)
        seq_pkg::ST_OFF:
        begin
          state_nxt = seq_pkg::ST_WAIT;
          timer_nxt = '0;
        end
        seq_pkg::ST_WAIT:
        begin
          if (timer_r == seq_pkg::TIMER_W'(HARD_RST_DELAY - 1))
          begin
            state_nxt = seq_pkg::ST_RAMP;
            timer_nxt = '0;
          end
          else
            timer_nxt = timer_r + 1'h1;
        end
        seq_pkg::ST_RAMP:
        begin
          if (timer_r == seq_pkg::TIMER_W'(RAMP_STEP - 1))
          begin
            state_nxt = seq_pkg::ST_ON;
            first_done_nxt = 1'h1;
            timer_nxt = '0;
          end
          else
            timer_nxt = timer_r + 1'h1;
        end
        seq_pkg::ST_ON:
        begin
          if (off_req)
            state_nxt = seq_pkg::ST_SOFT_OFF;
        end
        seq_pkg::ST_SOFT_OFF:
        begin
          if (on_req)
          begin
            state_nxt = seq_pkg::ST_RAMP;
            timer_nxt = '0;
          end
        end
        default:
        begin
          state_nxt = seq_pkg::ST_OFF;
          timer_nxt = '0;
        end
      endcase
    end
  end

  // First-power-up flag survives hard reset; only rst clears it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r <= seq_pkg::ST_OFF;
      timer_r <= '0;
      btn_cnt_r <= '0;
      btn_lvl_r <= 1'h1;
      first_done_r <= 1'h0;
    end
    else if (clock_en)
    begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      btn_cnt_r <= btn_cnt_nxt;
      btn_lvl_r <= btn_lvl_nxt;
      first_done_r <= first_done_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  seq_pkg::status_s stat_nxt;
  logic seq_term;
  logic supply_nxt, good_nxt, bank_nxt;

  // Sequencer term low for the whole sequence, high once on
  assign seq_term = (state_r == seq_pkg::ST_ON);

  // Next output values; the cold status gates both warm ones
  always_comb
  begin
    supply_nxt = (state_r == seq_pkg::ST_RAMP) || (state_r == seq_pkg::ST_ON);
    good_nxt = seq_term && power_ok;
    stat_nxt.cold_n = sync_r.cold_n & seq_term;
    // Cold reset drags both warm domains along; watchdog hits main domain
    stat_nxt.mcu_warm_n = stat_nxt.cold_n & sync_r.mcu_warm_n;
    stat_nxt.main_warm_n = stat_nxt.cold_n & sync_r.main_warm_n & !sync_r.wdog;
    bank_nxt = sync_r.vsel;
  end

  // Registered outputs; the carrier relies on power good before driving pins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      supply_enable <= 1'h0;
      power_sequence_done <= 1'h0;
      cold_reset_status_n <= seq_pkg::RST_ASSERTED;
      mcu_domain_warm_reset_status_n <= seq_pkg::RST_ASSERTED;
      main_domain_warm_reset_status_n <= seq_pkg::RST_ASSERTED;
      card_bank_supply <= seq_pkg::CARD_BANK_DEFAULT;
    end
    else if (clock_en)
    begin
      supply_enable <= supply_nxt;
      power_sequence_done <= good_nxt;
      cold_reset_status_n <= stat_nxt.cold_n;
      mcu_domain_warm_reset_status_n <= stat_nxt.mcu_warm_n;
      main_domain_warm_reset_status_n <= stat_nxt.main_warm_n;
      card_bank_supply <= bank_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_ramp_done;
    state_r == seq_pkg::ST_RAMP && timer_r == seq_pkg::TIMER_W'(RAMP_STEP - 1) && power_ok && clock_en;
  endsequence

  a_hard_reset_off: assert property (@(posedge clock) disable iff (rst)
    (clock_en && !power_ok) |=> state_r == seq_pkg::ST_OFF)
    else $error("sequencer not off under hard reset");
  a_wait_before_ramp: assert property (@(posedge clock) disable iff (rst)
    (state_r == seq_pkg::ST_RAMP && $past(state_r) == seq_pkg::ST_WAIT) |->
    $past(timer_r) == seq_pkg::TIMER_W'(HARD_RST_DELAY - 1))
    else $error("ramp started before delay");
  a_ramp_needs_power: assert property (@(posedge clock) disable iff (rst)
    (state_r == seq_pkg::ST_WAIT && clock_en) |-> ##1 (state_r != seq_pkg::ST_RAMP || $past(power_ok)))
    else $error("ramp without power");
  a_off_press: assert property (@(posedge clock) disable iff (rst)
    (state_r == seq_pkg::ST_ON && off_req && power_ok && clock_en) |=> state_r == seq_pkg::ST_SOFT_OFF)
    else $error("long press ignored");
  a_on_hold: assert property (@(posedge clock) disable iff (rst)
    (state_r == seq_pkg::ST_SOFT_OFF && on_req && power_ok && clock_en) |=> state_r == seq_pkg::ST_RAMP)
    else $error("on hold ignored");
  a_button_ignored: assert property (@(posedge clock) disable iff (rst)
    !first_done_r |-> (btn_cnt_r == '0 && !off_req && !on_req))
    else $error("button evaluated before first power-up");
  a_first_done: assert property (@(posedge clock) disable iff (rst)
    s_ramp_done |=> first_done_r && state_r == seq_pkg::ST_ON)
    else $error("first power-up not recorded");
  a_cold_and: assert property (@(posedge clock) disable iff (rst)
    clock_en |=> cold_reset_status_n == ($past(sync_r.cold_n) & $past(seq_term)))
    else $error("cold reset not the AND");
  a_good_after_seq: assert property (@(posedge clock) disable iff (rst)
    power_sequence_done |-> $past(state_r) == seq_pkg::ST_ON)
    else $error("power good before sequence done");
  a_wdog_warm: assert property (@(posedge clock) disable iff (rst)
    (clock_en && sync_r.wdog) |=> !main_domain_warm_reset_status_n)
    else $error("watchdog did not warm reset");

  // ----------------------------------------
  // Assertions on the power path
  // ----------------------------------------
  // Steps of the power-up walk shared by the checks below
  sequence s_waiting;
    state_r == seq_pkg::ST_WAIT && timer_r != seq_pkg::TIMER_W'(HARD_RST_DELAY - 1) && power_ok && clock_en;
  endsequence

  sequence s_on_kept;
    clock_en && power_ok && state_r == seq_pkg::ST_ON;
  endsequence

  // Regulators stay off while the sequencer sits in reset
  a_off_no_supply: assert property (@(posedge clock) disable iff (rst)
    (clock_en && state_r == seq_pkg::ST_OFF) |=> !supply_enable)
    else $error("supply enabled while off");

  // Delay runs to its end; a short wait would ramp too early
  a_wait_holds: assert property (@(posedge clock) disable iff (rst)
    s_waiting |=> state_r == seq_pkg::ST_WAIT)
    else $error("delay cut short");

  // Power good one edge after on; the carrier waits on it before driving
  a_good_follows_on: assert property (@(posedge clock) disable iff (rst)
    s_ramp_done ##1 s_on_kept |=> power_sequence_done)
    else $error("power good late");
  a_good_has_supply: assert property (@(posedge clock) disable iff (rst)
    power_sequence_done |-> supply_enable)
    else $error("power good without supply");

  // Button decisions move the state only at the exact count
  a_on_stays: assert property (@(posedge clock) disable iff (rst)
    (clock_en && power_ok && state_r == seq_pkg::ST_ON && !off_req) |=> state_r == seq_pkg::ST_ON)
    else $error("left on without long press");
  a_soft_off_holds: assert property (@(posedge clock) disable iff (rst)
    (clock_en && power_ok && state_r == seq_pkg::ST_SOFT_OFF && !on_req) |=> state_r == seq_pkg::ST_SOFT_OFF)
    else $error("left off without hold");

  // ----------------------------------------
  // Assertions on the reset status outputs
  // ----------------------------------------
  // A low cold input, or the sequencer out of on, pulls the cold status low
  a_cold_low: assert property (@(posedge clock) disable iff (rst)
    (clock_en && !sync_r.cold_n) |=> !cold_reset_status_n)
    else $error("cold input low not shown");
  a_cold_released: assert property (@(posedge clock) disable iff (rst)
    (clock_en && sync_r.cold_n && seq_term) |=> cold_reset_status_n)
    else $error("cold status stuck low");

  // Each warm input reaches its own domain and spares the other
  a_mcu_warm: assert property (@(posedge clock) disable iff (rst)
    (clock_en && !sync_r.mcu_warm_n) |=> !mcu_domain_warm_reset_status_n)
    else $error("mcu warm reset not applied");
  a_mcu_spares_main: assert property (@(posedge clock) disable iff (rst)
    (clock_en && sync_r.cold_n && seq_term && sync_r.main_warm_n && !sync_r.wdog) |=>
    main_domain_warm_reset_status_n)
    else $error("mcu warm reset hit main domain");
  a_main_warm: assert property (@(posedge clock) disable iff (rst)
    (clock_en && !sync_r.main_warm_n) |=> !main_domain_warm_reset_status_n)
    else $error("main warm reset not applied");
  a_main_spares_mcu: assert property (@(posedge clock) disable iff (rst)
    (clock_en && sync_r.cold_n && seq_term && sync_r.mcu_warm_n) |=>
    mcu_domain_warm_reset_status_n)
    else $error("main warm reset hit mcu domain");

  // Cold reset drags both warm statuses along
  a_warm_in_cold: assert property (@(posedge clock) disable iff (rst)
    !cold_reset_status_n |-> (!mcu_domain_warm_reset_status_n && !main_domain_warm_reset_status_n))
    else $error("warm status released under cold reset");

  // Bank select is the synchronised pin, one edge on
  a_bank_follows: assert property (@(posedge clock) disable iff (rst)
    clock_en |=> card_bank_supply == $past(sync_r.vsel))
    else $error("bank select not followed");

  // ----------------------------------------
  // Assertions on synchronisers and enable
  // ----------------------------------------
  // Two flops in a row, and a low enable holds every count
  a_sync_chain: assert property (@(posedge clock) disable iff (rst)
    clock_en |=> sync_r == $past(meta_r))
    else $error("synchroniser skipped a stage");
  a_enable_freeze: assert property (@(posedge clock) disable iff (rst)
    !clock_en |=> ($stable(state_r) && $stable(timer_r) && $stable(btn_cnt_r) &&
    $stable(power_sequence_done)))
    else $error("state moved while frozen");

endmodule // module_reset_power_sequencer

// >>> verif/carrier_board_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Carrier board controller
// ----------------------------------------
module carrier_board_model (
  input wire logic power_sequence_done,
  input wire logic [3:0] req,
  output logic cold_reset_in_n,
  output logic mcu_domain_warm_reset_n,
  output logic main_domain_warm_reset_req_n,
  output logic card_bank_voltage_select
);
  // Pull-ups hold every line high; the board only pulls low once power good is seen,
  // so any early request is simply not put on the pin
  assign cold_reset_in_n = !(req[0] && power_sequence_done);
  assign mcu_domain_warm_reset_n = !(req[1] && power_sequence_done);
  assign main_domain_warm_reset_req_n = !(req[2] && power_sequence_done);
  assign card_bank_voltage_select = !(req[3] && power_sequence_done);
endmodule // carrier_board_model

// >>> verif/test_module_reset_power_sequencer.sv
`timescale 1ns/1ps
module test_module_reset_power_sequencer;
  // ----------------------------------------
  // Shortened counts
  // ----------------------------------------
  localparam int unsigned DLY = 20;
  localparam int unsigned OFFP = 30;
  localparam int unsigned ONH = 15;
  localparam int unsigned RMP = 5;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic hard_n = 1'h0;
  logic button_n = 1'h1;
  logic supply = 1'h0;
  logic wdog = 1'h0;
  logic clock_en = 1'h1;
  logic [3:0] req = 4'h0;
  logic cold_n, mcu_n, main_n, vsel, sup_en, cold_st, mcu_st, main_st, done, bank;
  int fail_count = 0;
  int n_compared = 0;
  // Stimulus {watchdog, board requests} and expected {cold, mcu, main, bank}
  logic [4:0] t_in [6] = '{5'h01, 5'h02, 5'h04, 5'h10, 5'h08, 5'h00};
  logic [3:0] t_exp [6] = '{4'h1, 4'hB, 4'hD, 4'hD, 4'hE, 4'hF};

  always #4 clock = ~clock;

  module_reset_power_sequencer #(.HARD_RST_DELAY(DLY), .PWR_OFF_PRESS(OFFP), .PWR_ON_HOLD(ONH),
    .RAMP_STEP(RMP)) u_module_reset_power_sequencer (.clock(clock), .rst(rst), .clock_en(clock_en),
    .module_power_cycle_reset_n(hard_n), .power_button_n(button_n), .cold_reset_in_n(cold_n),
    .mcu_domain_warm_reset_n(mcu_n), .main_domain_warm_reset_req_n(main_n),
    .main_supply_present(supply), .card_bank_voltage_select(vsel), .watchdog_expired(wdog),
    .supply_enable(sup_en), .cold_reset_status_n(cold_st), .mcu_domain_warm_reset_status_n(mcu_st),
    .main_domain_warm_reset_status_n(main_st), .power_sequence_done(done), .card_bank_supply(bank));

  carrier_board_model u_carrier_board_model (.power_sequence_done(done), .req(req),
    .cold_reset_in_n(cold_n), .mcu_domain_warm_reset_n(mcu_n),
    .main_domain_warm_reset_req_n(main_n), .card_bank_voltage_select(vsel));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Inputs always move 1 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check("idle", 4'h1, {done, mcu_st, main_st, bank});
  endtask

  // Button pressed as power returns: its run may only start once on
  task automatic t_power_up;
    supply = 1'h1;
    cyc(DLY + 20);
    check("hard low", 4'h0, {2'h0, done, sup_en});
    supply = 1'h0;
    hard_n = 1'h1;
    cyc(DLY + 20);
    check("no supply", 4'h0, {3'h0, done});
    button_n = 1'h0;
    supply = 1'h1;
    cyc(DLY + 3);
    check("waiting", 4'h0, {2'h0, done, cold_st});
    cyc(RMP + 6);
    check("up", 4'hF, {done, cold_st, mcu_st, main_st});
    cyc(4);
    button_n = 1'h1;
    cyc(4);
    check("ignored", 4'h1, {3'h0, done});
  endtask

  task automatic t_resets;
    for (int i = 0; i < 6; i++)
    begin
      {wdog, req} = t_in[i];
      cyc(5);
      check("status", t_exp[i], {cold_st, mcu_st, main_st, bank});
    end
  endtask

  // A low enable must hold every output; the request lands once it rises
  task automatic t_freeze;
    clock_en = 1'h0;
    req = 4'h1;
    cyc(8);
    check("frozen", 4'hF, {cold_st, mcu_st, main_st, bank});
    clock_en = 1'h1;
    cyc(5);
    check("thawed", 4'h1, {cold_st, mcu_st, main_st, bank});
    req = 4'h0;
    cyc(5);
    check("released", 4'hF, {cold_st, mcu_st, main_st, bank});
  endtask

  // A short release in mid-press restarts the long-press count
  task automatic t_button;
    button_n = 1'h0;
    cyc(OFFP - 5);
    button_n = 1'h1;
    cyc(2);
    button_n = 1'h0;
    cyc(OFFP - 5);
    check("press", 4'h1, {3'h0, done});
    cyc(12);
    check("off", 4'h0, {2'h0, done, sup_en});
    button_n = 1'h1;
    cyc(ONH - 5);
    check("early on", 4'h0, {3'h0, done});
    cyc(RMP + 12);
    check("on", 4'h1, {3'h0, done});
  endtask

  task automatic t_hard;
    hard_n = 1'h0;
    cyc(6);
    check("cycle", 4'h0, {2'h0, done, sup_en});
    hard_n = 1'h1;
    cyc(DLY + 3);
    check("delay", 4'h0, {3'h0, sup_en});
    cyc(1);
    check("ramp", 4'h1, {3'h0, sup_en});
    cyc(RMP + 10);
    check("again", 4'h1, {3'h0, done});
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial
  begin
    cyc(3);
    rst = 1'h0;
    t_reset;
    t_power_up;
    t_resets;
    t_freeze;
    t_button;
    t_hard;
    results;
  end

  // Whole run is some 300 cycles; 2000 leaves ample slack
  initial
  begin
    #(8 * 2000);
    fail_count++;
    results;
  end
endmodule // test_module_reset_power_sequencer
